/* wdt_pkg.sv */
package wdt_pkg;

   // =====================================================
   // sizes
   localparam int NUM_OUT = 15;
   localparam int IVL_W = 16;
   localparam int PRESC_W = 22;

   // =====================================================
   // reset and special values
   localparam logic [IVL_W-1:0] IVL_DISABLED = 16'hFFFF;
   localparam logic [IVL_W-1:0] IVL_RST = 16'hFFFF;
   localparam logic [IVL_W-1:0] PRESET_RST = 16'h0000;

   // =====================================================
   // timing: one watchdog tick is 10 ms
   localparam int TICK_PERIOD_NS = 10_000_000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_CYCLES_DEF =
      (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // =====================================================
   // timer states
   typedef enum logic [2:0] {
      WDT_OFF  = 3'h1,
      WDT_RUN  = 3'h2,
      WDT_TRIP = 3'h4
   } wdt_state_type;

   function automatic logic ivl_disabled(input logic [IVL_W-1:0] ivl);
      return ivl == IVL_DISABLED;
   endfunction

endpackage

/* wdt_if.sv */
`timescale 1ns/10ps
interface wdt_if;
   logic restart;
   logic [wdt_pkg::IVL_W-1:0] interval;
   logic fire;
   wdt_pkg::wdt_state_type state;
   logic [wdt_pkg::IVL_W-1:0] ticks;

   modport timer (
      input restart,
      input interval,
      output fire,
      output state,
      output ticks
   );

   modport ctrl (
      output restart,
      output interval,
      input fire,
      input state,
      input ticks
   );
endinterface

/* wdt_timer.sv */
`timescale 1ns/10ps
module wdt_timer #(
   parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES_DEF
) (
   input wire logic clk_i,   // module clock
   input wire logic rst_n_i, // sync reset, active low
   input wire logic ce_i,    // clock enable
   wdt_if.timer wd           // restart in, trip out
);

   // =====================================================
   // state
   typedef struct packed {
      wdt_pkg::wdt_state_type state;
      logic [wdt_pkg::PRESC_W-1:0] presc;
      logic [wdt_pkg::IVL_W-1:0] ticks;
      logic fire;
   } tmr_type;

   localparam tmr_type TMR_RST = '{
      state: wdt_pkg::WDT_OFF,
      presc: '0,
      ticks: '0,
      fire: 1'b0
   };
   localparam logic [wdt_pkg::PRESC_W-1:0] PRESC_LAST =
      wdt_pkg::PRESC_W'(TICK_CYCLES - 1);

   tmr_type s_q, s_d;
   logic dis;

   assign dis = wdt_pkg::ivl_disabled(wd.interval);

   always_comb begin
      s_d = s_q;
      s_d.fire = 1'b0;
      if (wd.restart) begin
         // any message clears the count; the interval starts again unless disabled
         s_d.presc = '0;
         s_d.ticks = '0;
         s_d.state = dis ? wdt_pkg::WDT_OFF : wdt_pkg::WDT_RUN;
      end else begin
         case (s_q.state)
            wdt_pkg::WDT_OFF: begin
               if (!dis) begin
                  s_d.presc = '0;
                  s_d.ticks = '0;
                  s_d.state = wdt_pkg::WDT_RUN;
               end
            end
            wdt_pkg::WDT_RUN: begin
               if (dis) begin
                  s_d.state = wdt_pkg::WDT_OFF;
               end else if (s_q.ticks >= wd.interval) begin
                  s_d.state = wdt_pkg::WDT_TRIP;
                  s_d.fire = 1'b1;
               end else if (s_q.presc == PRESC_LAST) begin
                  s_d.presc = '0;
                  s_d.ticks = wdt_pkg::IVL_W'(s_q.ticks + 1'b1);
               end else begin
                  s_d.presc = wdt_pkg::PRESC_W'(s_q.presc + 1'b1);
               end
            end
            wdt_pkg::WDT_TRIP: begin
               if (dis) begin
                  s_d.state = wdt_pkg::WDT_OFF;
               end
            end
            default: begin
               s_d = TMR_RST;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= TMR_RST;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign wd.fire = s_q.fire;
   assign wd.state = s_q.state;
   assign wd.ticks = s_q.ticks;

   // =====================================================
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence seq_due;
      ce_i && !wd.restart && s_q.state == wdt_pkg::WDT_RUN && !dis &&
         s_q.ticks >= wd.interval;
   endsequence

   sequence seq_trip;
      wd.fire && s_q.state == wdt_pkg::WDT_TRIP;
   endsequence

   chk_trip_when_due: assert property (seq_due |=> seq_trip)
      else $error("watchdog did not trip when interval elapsed");

   chk_disabled_no_trip: assert property (
      ce_i && dis |=> !wd.fire)
      else $error("watchdog tripped while disabled");

   chk_restart_clears: assert property (
      ce_i && wd.restart |=> s_q.ticks == '0 && s_q.presc == '0 &&
         !wd.fire && s_q.state != wdt_pkg::WDT_TRIP)
      else $error("message did not restart the watchdog");

   chk_tick_step: assert property (
      ce_i && !wd.restart && s_q.state == wdt_pkg::WDT_RUN && !dis &&
         s_q.ticks < wd.interval && s_q.presc == PRESC_LAST
         |=> s_q.ticks == $past(s_q.ticks) + 1'b1 && s_q.presc == '0)
      else $error("tick count did not advance at prescaler wrap");

   chk_fire_single: assert property (
      ce_i && wd.fire |=> !wd.fire)
      else $error("trip pulse longer than one cycle");

endmodule

/* output_comm_watchdog.sv */
`timescale 1ns/10ps
module output_comm_watchdog #(
   parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES_DEF
) (
   input wire logic CLK_SYS_I,                  // 250 MHz clock
   input wire logic RST_N_I,                    // sync reset, low
   input wire logic CE_I,                       // clock enable
   input wire logic MSG_VALID_I,                // message for us
   input wire logic OUT_WR_I,                   // output write
   input wire logic [wdt_pkg::NUM_OUT-1:0] OUT_DATA_I, // output data
   input wire logic IVL_WR_I,                   // interval write
   input wire logic [wdt_pkg::IVL_W-1:0] IVL_DATA_I, // interval data
   input wire logic PRESET_WR_I,                // preset write
   input wire logic [wdt_pkg::IVL_W-1:0] PRESET_DATA_I, // preset data
   output logic [wdt_pkg::NUM_OUT-1:0] OUT_O,   // output channels
   output logic SAFE_O,                         // safe preset active
   output logic [wdt_pkg::IVL_W-1:0] IVL_O,     // interval readback
   output logic [wdt_pkg::IVL_W-1:0] PRESET_O,  // preset readback
   output logic [wdt_pkg::IVL_W-1:0] TICKS_O    // elapsed ticks
);

   // =====================================================
   // state
   typedef struct packed {
      logic [wdt_pkg::NUM_OUT-1:0] outs;
      logic [wdt_pkg::IVL_W-1:0] ivl;
      logic [wdt_pkg::IVL_W-1:0] preset;
      logic safe;
   } top_type;

   localparam top_type TOP_RST = '{
      outs: wdt_pkg::PRESET_RST[wdt_pkg::NUM_OUT-1:0],
      ivl: wdt_pkg::IVL_RST,
      preset: wdt_pkg::PRESET_RST,
      safe: 1'b0
   };

   top_type s_q, s_d;
   logic [wdt_pkg::NUM_OUT-1:0] out_next;
   logic any_msg;

   wdt_if wd ();

   // =====================================================
   // watchdog timer
   assign any_msg = MSG_VALID_I | OUT_WR_I | IVL_WR_I | PRESET_WR_I;
   assign wd.restart = any_msg;
   assign wd.interval = s_q.ivl;

   wdt_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .wd(wd)
   );

   // =====================================================
   // per-channel output select, host write beats trip load
   genvar ch;
   generate
      for (ch = 0; ch < wdt_pkg::NUM_OUT; ch++) begin : g_ch
         assign out_next[ch] = OUT_WR_I ? OUT_DATA_I[ch] :
            (wd.fire ? s_q.preset[ch] : s_q.outs[ch]);

         chk_chan_load: assert property (
            @(posedge CLK_SYS_I) disable iff (!RST_N_I)
            CE_I && wd.fire && !OUT_WR_I
               |=> OUT_O[ch] == $past(s_q.preset[ch]))
            else $error("channel not loaded from its preset bit");
      end
   endgenerate

   always_comb begin
      s_d = s_q;
      s_d.outs = out_next;
      if (IVL_WR_I) begin
         s_d.ivl = IVL_DATA_I;
      end
      if (PRESET_WR_I) begin
         s_d.preset = PRESET_DATA_I;
      end
      // trip sets, a message clears; set wins
      if (wd.fire) begin
         s_d.safe = 1'b1;
      end else if (any_msg) begin
         s_d.safe = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         s_q <= TOP_RST;
      end else if (CE_I) begin
         s_q <= s_d;
      end
   end

   assign OUT_O = s_q.outs;
   assign SAFE_O = s_q.safe;
   assign IVL_O = s_q.ivl;
   assign PRESET_O = s_q.preset;
   assign TICKS_O = wd.ticks;

   // =====================================================
   // checks
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RST_N_I);

   chk_safe_load: assert property (
      CE_I && wd.fire && !OUT_WR_I
         |=> s_q.outs == $past(s_q.preset[wdt_pkg::NUM_OUT-1:0]))
      else $error("outputs not loaded with safe preset on trip");

   chk_out_write: assert property (
      CE_I && OUT_WR_I |=> OUT_O == $past(OUT_DATA_I))
      else $error("output write not applied");

   chk_preset_reset: assert property (
      disable iff (1'b0) !RST_N_I |=> PRESET_O == wdt_pkg::PRESET_RST &&
         OUT_O == '0)
      else $error("preset or outputs not zero after reset");

   chk_ivl_reset: assert property (
      disable iff (1'b0) !RST_N_I |=> IVL_O == wdt_pkg::IVL_DISABLED &&
         wd.state == wdt_pkg::WDT_OFF)
      else $error("interval not disabled after reset");

   chk_ivl_write: assert property (
      CE_I && IVL_WR_I |=> IVL_O == $past(IVL_DATA_I))
      else $error("interval write not stored");

   chk_preset_write: assert property (
      CE_I && PRESET_WR_I |=> PRESET_O == $past(PRESET_DATA_I))
      else $error("preset write not stored");

   chk_ivl_hold: assert property (
      CE_I && !IVL_WR_I |=> $stable(IVL_O))
      else $error("interval changed without a write");

   chk_preset_hold: assert property (
      CE_I && !PRESET_WR_I |=> $stable(PRESET_O))
      else $error("preset changed without a write");

   // =====================================================
   // safe flag steps
   sequence seq_msg_only;
      CE_I && any_msg && !wd.fire;
   endsequence

   sequence seq_idle;
      CE_I && !any_msg && !wd.fire;
   endsequence

   chk_safe_raise: assert property (
      CE_I && wd.fire |=> SAFE_O)
      else $error("safe flag not raised on trip");

   chk_safe_clear: assert property (
      seq_msg_only |=> !SAFE_O)
      else $error("safe flag not cleared by a message");

   chk_safe_hold: assert property (
      seq_idle |=> $stable(SAFE_O))
      else $error("safe flag changed without an event");

   chk_out_hold: assert property (
      CE_I && !OUT_WR_I && !wd.fire |=> $stable(OUT_O))
      else $error("outputs changed without write or trip");

   chk_disabled_safe: assert property (
      CE_I && wdt_pkg::ivl_disabled(IVL_O) && !SAFE_O |=> !SAFE_O)
      else $error("safe state forced while watchdog disabled");

   chk_restart_ticks: assert property (
      CE_I && any_msg |=> TICKS_O == '0)
      else $error("message did not clear the tick count");

   chk_ce_freeze: assert property (
      !CE_I |=> $stable(OUT_O) && $stable(SAFE_O) && $stable(TICKS_O))
      else $error("state moved while clock enable low");

endmodule

/* modbus_host_model.sv */
`timescale 1ns/10ps
module modbus_host_model (
   input wire logic clk_i,                         // module clock
   output logic msg_o,                             // message strobe
   output logic out_wr_o,                          // output write
   output logic [wdt_pkg::NUM_OUT-1:0] out_d_o,    // output data
   output logic ivl_wr_o,                          // interval write
   output logic [wdt_pkg::IVL_W-1:0] ivl_d_o,      // interval data
   output logic pre_wr_o,                          // preset write
   output logic [wdt_pkg::IVL_W-1:0] pre_d_o       // preset data
);
   initial begin
      {msg_o, out_wr_o, ivl_wr_o, pre_wr_o} = 4'h0;
      out_d_o = '0;
      ivl_d_o = '0;
      pre_d_o = '0;
   end

   // =====================================================
   // one register write: 0 message, 1 outputs, 2 interval, 3 preset
   task automatic send(input int sel, input logic [15:0] d);
      @(posedge clk_i);
      case (sel)
         0: msg_o <= 1'h1;
         1: begin
            out_wr_o <= 1'h1;
            out_d_o <= d[14:0];
         end
         2: begin
            ivl_wr_o <= 1'h1;
            ivl_d_o <= d;
         end
         default: begin
            pre_wr_o <= 1'h1;
            pre_d_o <= d;
         end
      endcase
      @(posedge clk_i);
      {msg_o, out_wr_o, ivl_wr_o, pre_wr_o} <= 4'h0;
      // released data does not keep the last value
      out_d_o <= ~out_d_o;
      ivl_d_o <= ~ivl_d_o;
      pre_d_o <= ~pre_d_o;
   endtask
endmodule

/* output_comm_watchdog_test.sv */
`timescale 1ns/10ps
module output_comm_watchdog_test;
   localparam int TC = 4;
   logic clk, rst_n, ce, msg, owr, iwr, pwr, safe;
   logic [wdt_pkg::NUM_OUT-1:0] od, out;
   logic [wdt_pkg::IVL_W-1:0] id, pd, ivl, pre, ticks, o, p, v;
   logic [31:0] seed, r;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   modbus_host_model host (.clk_i(clk), .msg_o(msg), .out_wr_o(owr),
      .out_d_o(od), .ivl_wr_o(iwr), .ivl_d_o(id), .pre_wr_o(pwr),
      .pre_d_o(pd));

   output_comm_watchdog #(.TICK_CYCLES(TC)) dut (.CLK_SYS_I(clk),
      .RST_N_I(rst_n), .CE_I(ce), .MSG_VALID_I(msg), .OUT_WR_I(owr),
      .OUT_DATA_I(od), .IVL_WR_I(iwr), .IVL_DATA_I(id), .PRESET_WR_I(pwr),
      .PRESET_DATA_I(pd), .OUT_O(out), .SAFE_O(safe), .IVL_O(ivl),
      .PRESET_O(pre), .TICKS_O(ticks));

   // =====================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [15:0] pattern(input logic [15:0] pv);
      return {1'h0, pv[14:0]};
   endfunction

   task automatic check_word(string n, logic [15:0] e, logic [15:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   task automatic check_flag(string n, logic e, logic g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %b seen %b", n, e, g);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   // =====================================================
   // main sequence
   initial begin
      seed = 32'h00009C4E;
      rst_n <= 1'h0;
      ce <= 1'h1;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      #1;
      check_word("outputs", 16'h0000, {1'h0, out});
      check_word("preset", 16'h0000, pre);
      check_word("interval", 16'hFFFF, ivl);
      repeat (200) @(posedge clk);
      #1;
      check_flag("safe", 1'h0, safe);
      check_word("ticks", 16'h0000, ticks);
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         o = r[15:0];
         r = rnd();
         p = (i == 1) ? 16'h7FFF : r[15:0];
         r = rnd();
         // zero interval last: a zero left running would trip mid-setup
         v = (i == 7) ? 16'h0000 : 16'(r % 5 + 1);
         host.send(1, o);
         #1;
         check_word("outputs", pattern(o), {1'h0, out});
         host.send(3, p);
         #1;
         check_word("preset", p, pre);
         host.send(2, v);
         #1;
         check_word("interval", v, ivl);
         if (v != 16'h0000) begin
            repeat (2) @(posedge clk);
            host.send(0, 16'h0000);
            #1;
         end
         check_word("ticks", 16'h0000, ticks);
         repeat (v * TC) @(posedge clk);
         #1;
         check_word("ticks", v, ticks);
         @(posedge clk);
         #1;
         check_flag("safe", 1'h0, safe);
         check_word("outputs", pattern(o), {1'h0, out});
         @(posedge clk);
         #1;
         check_flag("safe", 1'h1, safe);
         check_word("outputs", pattern(p), {1'h0, out});
      end
      // clock enable low: a write must leave no trace
      @(posedge clk);
      ce <= 1'h0;
      host.send(1, ~p);
      #1;
      check_flag("safe", 1'h1, safe);
      check_word("outputs", pattern(p), {1'h0, out});
      @(posedge clk);
      ce <= 1'h1;
      host.send(2, 16'h0003);
      repeat (5) @(posedge clk);
      host.send(2, 16'hFFFF);
      repeat (100) @(posedge clk);
      #1;
      check_flag("safe", 1'h0, safe);
      check_word("ticks", 16'h0000, ticks);
      finish_test();
   end
endmodule
